/* verilog/fcr_pkg.sv */
// constants, field layouts and carrier types for the fan output and pin configuration bank
package fcr_pkg;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] OFS_FAN_HI_DIVISOR = 8'h03;
   localparam logic [7:0] OFS_FAN_DAC_VALUE = 8'h04;
   localparam logic [7:0] OFS_FAN_PWM_VALUE = 8'h05;
   localparam logic [7:0] OFS_FACTORY_RESERVED_A = 8'h06;
   localparam logic [7:0] OFS_MISC_CONFIG_THREE = 8'h07;
   localparam logic [7:0] OFS_PIN_DIR_POL_LOW = 8'h08;
   localparam logic [7:0] OFS_PIN_DIR_POL_MID = 8'h09;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_FAN_HI_DIVISOR = 8'h55;
   localparam logic [7:0] RST_FAN_DAC_VALUE = 8'hFF;
   localparam logic [7:0] RST_FAN_PWM_VALUE = 8'hFF;
   localparam logic [7:0] RST_FACTORY_RESERVED_A = 8'h00;
   localparam logic [7:0] RST_MISC_CONFIG_THREE = 8'h00;
   localparam logic [7:0] RST_PIN_DIR_POL_LOW = 8'h00;
   localparam logic [7:0] RST_PIN_DIR_POL_MID = 8'h00;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int CFG3_PIN16_SEL_BIT = 0;
   localparam int CFG3_CI_CLEAR_BIT = 1;
   localparam int CFG3_VREF_SEL_BIT = 2;
   localparam int CFG3_PIN16_DIR_BIT = 6;
   localparam int CFG3_PIN16_POL_BIT = 7;
   localparam logic [7:0] CFG3_WRITABLE_MASK = 8'hC7;
   localparam int PWM_CODE_LSB = 4;
   localparam int MIN_SPEED_LSB = 4;
   localparam logic [3:0] PWM_CODE_FULL = 4'hF;
   localparam logic [3:0] PWM_SLOTS_LAST = 4'hE;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_HZ = 50000000;
   localparam int MEAS_FREQ_HZ = 22500;
   // longest whole period that does not run slower than the measurement rate
   localparam int MEAS_TICK_CYCLES = CLK_HZ / MEAS_FREQ_HZ;
   localparam int PWM_SLOT_CYCLES_DEF = 16;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fcr_reg_req_s;

   typedef struct packed {
      logic [8:0] o;
      logic [8:0] oe;
   } fcr_pin_drv_s;

endpackage

/* verilog/fcr_bank.sv */
// fan divisor, fan drive, pin configuration register bank and its output logic
`timescale 1ns/1ps

module fcr_bank
#(
   parameter int PWM_SLOT_CYCLES = fcr_pkg::PWM_SLOT_CYCLES_DEF,
   parameter int MEAS_CYCLES = fcr_pkg::MEAS_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire fcr_pkg::fcr_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic dac_afc_en,
   input wire logic pwm_afc_en,
   input wire logic [7:0] afc_dac_level,
   input wire logic [3:0] afc_pwm_code,
   output logic [7:0] fan_dac_out,
   output logic fan_pwm_out,
   output logic [3:0] fan_meas_tick,
   input wire logic [7:0] general_pin_enable,
   input wire logic [8:0] pin_i,
   output fcr_pkg::fcr_pin_drv_s pin_drv,
   input wire logic [8:0] general_pin_out_data,
   output logic [8:0] general_pin_in_data,
   output logic [7:0] fan_tach_level,
   input wire logic thermal_alarm_assert,
   output logic thermal_alarm_sense,
   input wire logic intrusion_event_pin,
   output logic chassis_intrusion_latch,
   output logic vref_high_sel
);

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (PWM_SLOT_CYCLES < 1 || PWM_SLOT_CYCLES > 65535)
   begin : g_bad_slot
      $error("PWM_SLOT_CYCLES out of range");
   end
   if (MEAS_CYCLES < 2 || MEAS_CYCLES > 65535)
   begin : g_bad_meas
      $error("MEAS_CYCLES out of range");
   end

   // ***************************************************************
   // helper functions
   // ***************************************************************
   // larger of the automatic level and the programmed floor
   function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
      max8 = (a > b) ? a : b;
   endfunction

   // apply a polarity bit: 0 active low, 1 active high
   function automatic logic polar(input logic level, input logic pol_high);
      polar = pol_high ? level : ~level;
   endfunction

   // ***************************************************************
   // registers
   // ***************************************************************
   logic [7:0] fan_hi_divisor_reg;
   logic [7:0] fan_dac_value_reg;
   logic [7:0] fan_pwm_value_reg;
   logic [7:0] factory_reserved_a_reg;
   logic [7:0] misc_config_three_reg;
   logic [7:0] pin_dir_pol_low_reg;
   logic [7:0] pin_dir_pol_mid_reg;

   // host writes; each register loads its power-on value at reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fan_hi_divisor_reg <= fcr_pkg::RST_FAN_HI_DIVISOR;
         fan_dac_value_reg <= fcr_pkg::RST_FAN_DAC_VALUE;
         fan_pwm_value_reg <= fcr_pkg::RST_FAN_PWM_VALUE;
         factory_reserved_a_reg <= fcr_pkg::RST_FACTORY_RESERVED_A;
         misc_config_three_reg <= fcr_pkg::RST_MISC_CONFIG_THREE;
         pin_dir_pol_low_reg <= fcr_pkg::RST_PIN_DIR_POL_LOW;
         pin_dir_pol_mid_reg <= fcr_pkg::RST_PIN_DIR_POL_MID;
      end
      else if (reg_req.wr)
      begin
         case (reg_req.addr)
            fcr_pkg::OFS_FAN_HI_DIVISOR: fan_hi_divisor_reg <= reg_req.wdata;
            fcr_pkg::OFS_FAN_DAC_VALUE: fan_dac_value_reg <= reg_req.wdata;
            fcr_pkg::OFS_FAN_PWM_VALUE: fan_pwm_value_reg <= reg_req.wdata;
            // kept as plain storage; the host is expected to leave it alone
            fcr_pkg::OFS_FACTORY_RESERVED_A: factory_reserved_a_reg <= reg_req.wdata;
            // unused bits are never stored, so they read zero
            fcr_pkg::OFS_MISC_CONFIG_THREE: misc_config_three_reg <= reg_req.wdata & fcr_pkg::CFG3_WRITABLE_MASK;
            fcr_pkg::OFS_PIN_DIR_POL_LOW: pin_dir_pol_low_reg <= reg_req.wdata;
            fcr_pkg::OFS_PIN_DIR_POL_MID: pin_dir_pol_mid_reg <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // read port
   // ***************************************************************
   logic [7:0] rd_mux;

   // read data mux; unmapped offsets answer zero
   always_comb
   begin
      case (reg_req.addr)
         fcr_pkg::OFS_FAN_HI_DIVISOR: rd_mux = fan_hi_divisor_reg;
         fcr_pkg::OFS_FAN_DAC_VALUE: rd_mux = fan_dac_value_reg;
         fcr_pkg::OFS_FAN_PWM_VALUE: rd_mux = fan_pwm_value_reg;
         fcr_pkg::OFS_FACTORY_RESERVED_A: rd_mux = factory_reserved_a_reg;
         fcr_pkg::OFS_MISC_CONFIG_THREE: rd_mux = misc_config_three_reg;
         fcr_pkg::OFS_PIN_DIR_POL_LOW: rd_mux = pin_dir_pol_low_reg;
         fcr_pkg::OFS_PIN_DIR_POL_MID: rd_mux = pin_dir_pol_mid_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   // read answer one cycle after the request, held until the next read
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd)
         begin
            reg_rdata <= rd_mux;
         end
      end
   end

   // ***************************************************************
   // tach measurement clock
   // ***************************************************************
   logic [15:0] meas_cnt_reg;
   logic meas_base;
   logic [2:0] prescale_reg;

   // base tick at the undivided measurement rate
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meas_cnt_reg <= 16'h0000;
      end
      else if (meas_base)
      begin
         meas_cnt_reg <= 16'h0000;
      end
      else
      begin
         meas_cnt_reg <= meas_cnt_reg + 16'h0001;
      end
   end
   assign meas_base = (meas_cnt_reg == 16'(MEAS_CYCLES - 1));

   // shared binary prescaler; all channels stay phase related
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prescale_reg <= 3'h0;
      end
      else if (meas_base)
      begin
         prescale_reg <= prescale_reg + 3'h1;
      end
   end

   // per channel tick; a count of 153 ticks per two tach pulses marks the nominal speed,
   // which halves with each doubling of the divisor
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fan_meas_tick <= 4'h0;
      end
      else
      begin
         for (int ch = 0; ch < 4; ch++)
         begin
            case (fan_hi_divisor_reg[2*ch +: 2])
               2'h0: fan_meas_tick[ch] <= meas_base;
               2'h1: fan_meas_tick[ch] <= meas_base && (prescale_reg[0] == 1'b1);
               2'h2: fan_meas_tick[ch] <= meas_base && (prescale_reg[1:0] == 2'h3);
               default: fan_meas_tick[ch] <= meas_base && (prescale_reg == 3'h7);
            endcase
         end
      end
   end

   // ***************************************************************
   // fan speed dac
   // ***************************************************************
   logic [7:0] dac_floor;

   // in auto mode the upper nibble is a floor under the temperature level
   assign dac_floor = {fan_dac_value_reg[7:fcr_pkg::MIN_SPEED_LSB], 4'h0};

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fan_dac_out <= fcr_pkg::RST_FAN_DAC_VALUE;
      end
      else if (dac_afc_en)
      begin
         fan_dac_out <= max8(afc_dac_level, dac_floor);
      end
      else
      begin
         fan_dac_out <= fan_dac_value_reg;
      end
   end

   // ***************************************************************
   // pwm output
   // ***************************************************************
   logic [3:0] pwm_code;
   logic [3:0] pwm_floor;
   logic [15:0] slot_cnt_reg;
   logic [3:0] slot_idx_reg;
   logic slot_end;

   assign pwm_floor = fan_pwm_value_reg[7:fcr_pkg::PWM_CODE_LSB];
   // auto mode never runs the fan below the programmed minimum
   assign pwm_code = pwm_afc_en ? 4'(max8({4'h0, afc_pwm_code}, {4'h0, pwm_floor})) : pwm_floor;
   assign slot_end = (slot_cnt_reg == 16'(PWM_SLOT_CYCLES - 1));

   // fifteen equal slots per period; the code is the number of high slots
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         slot_cnt_reg <= 16'h0000;
         slot_idx_reg <= 4'h0;
      end
      else if (slot_end)
      begin
         slot_cnt_reg <= 16'h0000;
         slot_idx_reg <= (slot_idx_reg == fcr_pkg::PWM_SLOTS_LAST) ? 4'h0 : slot_idx_reg + 4'h1;
      end
      else
      begin
         slot_cnt_reg <= slot_cnt_reg + 16'h0001;
      end
   end

   // code 0 never high, code 15 always high
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fan_pwm_out <= 1'b1;
      end
      else
      begin
         fan_pwm_out <= (slot_idx_reg < pwm_code);
      end
   end

   // ***************************************************************
   // pin input synchronisers
   // ***************************************************************
   logic [8:0] pin_meta_reg;
   logic [8:0] pin_sync_reg;
   logic ci_meta_reg;
   logic ci_sync_reg;

   // two flops before anything looks at a pin
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_meta_reg <= 9'h000;
         pin_sync_reg <= 9'h000;
         ci_meta_reg <= 1'b0;
         ci_sync_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= pin_i;
         pin_sync_reg <= pin_meta_reg;
         ci_meta_reg <= intrusion_event_pin;
         ci_sync_reg <= ci_meta_reg;
      end
   end

   // ***************************************************************
   // chassis intrusion latch
   // ***************************************************************
   // clear holds while the bit is 1; a new event in that cycle still sets it
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         chassis_intrusion_latch <= 1'b0;
      end
      else if (ci_sync_reg)
      begin
         chassis_intrusion_latch <= 1'b1;
      end
      else if (misc_config_three_reg[fcr_pkg::CFG3_CI_CLEAR_BIT])
      begin
         chassis_intrusion_latch <= 1'b0;
      end
   end

   // ***************************************************************
   // general pins
   // ***************************************************************
   logic [8:0] pin_dir;
   logic [8:0] pin_pol;
   logic [8:0] pin_gen;
   logic pin16_gen;

   assign pin16_gen = misc_config_three_reg[fcr_pkg::CFG3_PIN16_SEL_BIT];

   // unpack direction (even) and polarity (odd) bits per pin
   always_comb
   begin
      for (int p = 0; p < 4; p++)
      begin
         pin_dir[p] = pin_dir_pol_low_reg[2*p];
         pin_pol[p] = pin_dir_pol_low_reg[2*p+1];
         pin_dir[p+4] = pin_dir_pol_mid_reg[2*p];
         pin_pol[p+4] = pin_dir_pol_mid_reg[2*p+1];
      end
      pin_dir[8] = misc_config_three_reg[fcr_pkg::CFG3_PIN16_DIR_BIT];
      pin_pol[8] = misc_config_three_reg[fcr_pkg::CFG3_PIN16_POL_BIT];
      pin_gen = {pin16_gen, general_pin_enable};
   end

   // pin drive; thermal alarm is open drain, pulled low while asserted
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_drv <= '0;
      end
      else
      begin
         for (int p = 0; p < 9; p++)
         begin
            pin_drv.o[p] <= polar(general_pin_out_data[p], pin_pol[p]);
            pin_drv.oe[p] <= pin_gen[p] && pin_dir[p];
         end
         if (!pin16_gen)
         begin
            pin_drv.o[8] <= 1'b0;
            pin_drv.oe[8] <= thermal_alarm_assert;
         end
      end
   end

   // sensed levels; tach channels see the raw level, general pins the asserted one
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         general_pin_in_data <= 9'h000;
         fan_tach_level <= 8'h00;
         thermal_alarm_sense <= 1'b0;
      end
      else
      begin
         for (int p = 0; p < 9; p++)
         begin
            general_pin_in_data[p] <= pin_gen[p] && polar(pin_sync_reg[p], pin_pol[p]);
         end
         fan_tach_level <= pin_sync_reg[7:0] & ~general_pin_enable;
         // an external pull low reads as an asserted alarm
         thermal_alarm_sense <= !pin16_gen && !pin_sync_reg[8];
      end
   end

   // ***************************************************************
   // reference select
   // ***************************************************************
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         vref_high_sel <= 1'b0;
      end
      else
      begin
         vref_high_sel <= misc_config_three_reg[fcr_pkg::CFG3_VREF_SEL_BIT];
      end
   end

endmodule // fcr_bank

/* testbench/fcr_bank_sva.sv */
// checker for the fan output and pin configuration bank ports
`timescale 1ns/1ps
module fcr_bank_sva
(
   input wire logic clk,
   input wire logic rst_b,
   input wire fcr_pkg::fcr_reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic dac_afc_en,
   input wire logic pwm_afc_en,
   input wire logic [7:0] afc_dac_level,
   input wire logic [3:0] afc_pwm_code,
   input wire logic [7:0] fan_dac_out,
   input wire logic fan_pwm_out,
   input wire logic [3:0] fan_meas_tick,
   input wire logic [7:0] general_pin_enable,
   input wire fcr_pkg::fcr_pin_drv_s pin_drv,
   input wire logic intrusion_event_pin,
   input wire logic chassis_intrusion_latch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ****
   // register port
   // ****
   a_rd_answer: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read got no answer");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
      else $error("answer without read");
   a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved");
   a_cfg3_unused: assert property (reg_rvalid && $past(reg_req.addr) == fcr_pkg::OFS_MISC_CONFIG_THREE |-> reg_rdata[5:3] == 3'h0)
      else $error("unused bits not zero");
   // ****
   // fan outputs
   // ****
   a_dac_direct: assert property ((reg_req.wr && reg_req.addr == fcr_pkg::OFS_FAN_DAC_VALUE && !dac_afc_en) ##1 !dac_afc_en
      |=> fan_dac_out == $past(reg_req.wdata, 2))
      else $error("dac not the written value");
   a_dac_floor: assert property (dac_afc_en && $past(dac_afc_en) && $stable(afc_dac_level) |-> fan_dac_out >= afc_dac_level)
      else $error("dac below automatic level");
   a_pwm_full: assert property ((pwm_afc_en && afc_pwm_code == 4'hF) [*3] |-> fan_pwm_out)
      else $error("full code not steady high");
   a_tick_pulse: assert property (fan_meas_tick[0] |=> !fan_meas_tick[0])
      else $error("tick longer than a cycle");
   // ****
   // pins and latch
   // ****
   a_tach_undriven: assert property ((pin_drv.oe[7:0] & ~general_pin_enable & ~$past(general_pin_enable)) == 8'h00)
      else $error("tach pin driven");
   a_intr_set: assert property (intrusion_event_pin [*5] |-> chassis_intrusion_latch)
      else $error("intrusion not latched");
   // main scenarios reached
   c_read: cover property (reg_rvalid && reg_rdata == 8'h55);
   c_latch: cover property (chassis_intrusion_latch);
   c_pin16: cover property (pin_drv.oe[8]);
endmodule // fcr_bank_sva

/* testbench/fcr_host_model.sv */
// host model issuing register reads and writes to the bank
`timescale 1ns/1ps
module fcr_host_model
(
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output fcr_pkg::fcr_reg_req_s reg_req
);
   // idle bus until the first request
   initial reg_req = '0;
   // one-cycle write strobe; the host never writes offset 06h
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // read strobe; answer is taken while rvalid stands, bounded wait
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      d = reg_rdata;
   endtask
endmodule // fcr_host_model

/* testbench/fcr_bank_test.sv */
// self-checking bench for the fan output and pin configuration bank
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module fcr_bank_test;
   localparam int SLOT = 2;
   localparam int MEAS = 8;
   typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} fcr_row_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   fcr_pkg::fcr_reg_req_s reg_req;
   fcr_pkg::fcr_pin_drv_s pin_drv;
   logic [7:0] reg_rdata, afc_dac_level, fan_dac_out, general_pin_enable, fan_tach_level, rd;
   logic reg_rvalid, dac_afc_en, pwm_afc_en, fan_pwm_out, thermal_alarm_assert, thermal_alarm_sense;
   logic intrusion_event_pin, chassis_intrusion_latch, vref_high_sel;
   logic [3:0] afc_pwm_code, fan_meas_tick;
   logic [8:0] pin_i, pin_ext, general_pin_out_data, general_pin_in_data;
   int mismatches = 0;
   int n_checks = 0;
   int h;
   // reset reads first, then write and read back, last one unmapped
   fcr_row_s rows [15] = '{{8'h03, 1'b0, 8'h00, 8'h55}, {8'h04, 1'b0, 8'h00, 8'hFF}, {8'h05, 1'b0, 8'h00, 8'hFF},
      {8'h06, 1'b0, 8'h00, 8'h00}, {8'h07, 1'b0, 8'h00, 8'h00}, {8'h08, 1'b0, 8'h00, 8'h00},
      {8'h09, 1'b0, 8'h00, 8'h00}, {8'h0A, 1'b0, 8'h00, 8'h00}, {8'h03, 1'b1, 8'hE4, 8'hE4},
      {8'h04, 1'b1, 8'h20, 8'h20}, {8'h05, 1'b1, 8'h7A, 8'h7A}, {8'h07, 1'b1, 8'hFF, 8'hC7},
      {8'h08, 1'b1, 8'h03, 8'h03}, {8'h09, 1'b1, 8'hC0, 8'hC0}, {8'h0A, 1'b1, 8'h55, 8'h00}};
   logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
   // automatic code in the high nibble, expected duty code in the low
   logic [7:0] acodes [3] = '{8'h99, 8'h37, 8'hFF};

   always #10 clk = ~clk;
   // a driven pin shows the bank's level, otherwise the outside level
   assign pin_i = (pin_drv.oe & pin_drv.o) | (~pin_drv.oe & pin_ext);

   fcr_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_req(reg_req));
   fcr_bank #(.PWM_SLOT_CYCLES(SLOT), .MEAS_CYCLES(MEAS)) dut_u (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_afc_en(dac_afc_en), .pwm_afc_en(pwm_afc_en),
      .afc_dac_level(afc_dac_level), .afc_pwm_code(afc_pwm_code), .fan_dac_out(fan_dac_out),
      .fan_pwm_out(fan_pwm_out), .fan_meas_tick(fan_meas_tick), .general_pin_enable(general_pin_enable),
      .pin_i(pin_i), .pin_drv(pin_drv), .general_pin_out_data(general_pin_out_data),
      .general_pin_in_data(general_pin_in_data), .fan_tach_level(fan_tach_level),
      .thermal_alarm_assert(thermal_alarm_assert), .thermal_alarm_sense(thermal_alarm_sense),
      .intrusion_event_pin(intrusion_event_pin), .chassis_intrusion_latch(chassis_intrusion_latch),
      .vref_high_sel(vref_high_sel));

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // high cycles over one whole pwm period of 15 slots
   task automatic pwm_high(output int c);
      c = 0;
      repeat (15 * SLOT)
      begin
         @(negedge clk);
         c += int'(fan_pwm_out === 1'b1);
      end
   endtask
   // cycles between two ticks of one channel, bounded so a dead tick cannot hang
   task automatic tick_period(input int ch, output int p);
      p = 0;
      while (fan_meas_tick[ch] !== 1'b1 && p < 200)
      begin
         @(negedge clk);
         p++;
      end
      p = 0;
      do
      begin
         @(negedge clk);
         p++;
      end
      while (fan_meas_tick[ch] !== 1'b1 && p < 200);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog: the sequence needs under a thousand cycles
   initial
   begin
      #(20 * 20000);
      mismatches++;
      end_of_test();
   end

   // main sequence
   initial
   begin
      {dac_afc_en, pwm_afc_en, afc_dac_level, afc_pwm_code, general_pin_enable} = '0;
      {general_pin_out_data, thermal_alarm_assert, intrusion_event_pin} = '0;
      pin_ext = 9'h1FF;
      cyc(8);
      rst_b = 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            host_u.write_reg(rows[i].a, rows[i].d);
         host_u.read_reg(rows[i].a, rd);
         `CHK(rd, rows[i].e)
      end
      `CHK(fan_dac_out, 8'h20)
      dac_afc_en = 1'b1;
      afc_dac_level = 8'h10;
      cyc(3);
      `CHK(fan_dac_out, 8'h20)
      afc_dac_level = 8'h90;
      cyc(3);
      `CHK(fan_dac_out, 8'h90)
      dac_afc_en = 1'b0;
      // duty codes 0, 1, 7 and 15, a full period after each change
      foreach (codes[i])
      begin
         host_u.write_reg(fcr_pkg::OFS_FAN_PWM_VALUE, {codes[i], 4'hA});
         cyc(34);
         pwm_high(h);
         `CHK(h, int'(codes[i]) * SLOT)
      end
      host_u.write_reg(fcr_pkg::OFS_FAN_PWM_VALUE, 8'h70);
      pwm_afc_en = 1'b1;
      foreach (acodes[i])
      begin
         afc_pwm_code = acodes[i][7:4];
         cyc(34);
         pwm_high(h);
         `CHK(h, int'(acodes[i][3:0]) * SLOT)
      end
      pwm_afc_en = 1'b0;
      // divisor codes 00..11 on fans 4..7
      for (int ch = 0; ch < 4; ch++)
      begin
         tick_period(ch, h);
         `CHK(h, MEAS << ch)
      end
      general_pin_enable = 8'h0F;
      general_pin_out_data = 9'h101;
      pin_ext = 9'h1ED;
      cyc(4);
      `CHK({pin_drv.oe[0], pin_drv.o[0]}, 2'b11)
      `CHK(general_pin_in_data[1], 1'b1)
      `CHK(pin_drv.oe[7:1], 7'h00)
      `CHK(fan_tach_level[7:4], 4'hE)
      `CHK({pin_drv.oe[8], pin_drv.o[8]}, 2'b11)
      `CHK(vref_high_sel, 1'b1)
      host_u.write_reg(fcr_pkg::OFS_PIN_DIR_POL_LOW, 8'h01);
      cyc(3);
      `CHK(pin_drv.o[0], 1'b0)
      host_u.write_reg(fcr_pkg::OFS_MISC_CONFIG_THREE, 8'h00);
      thermal_alarm_assert = 1'b1;
      cyc(4);
      `CHK({pin_drv.oe[8], pin_drv.o[8], thermal_alarm_sense}, 3'b101)
      `CHK(vref_high_sel, 1'b0)
      // latch holds after the event until the clear bit is written
      intrusion_event_pin = 1'b1;
      cyc(6);
      intrusion_event_pin = 1'b0;
      cyc(6);
      `CHK(chassis_intrusion_latch, 1'b1)
      host_u.write_reg(fcr_pkg::OFS_MISC_CONFIG_THREE, 8'h02);
      cyc(2);
      `CHK(chassis_intrusion_latch, 1'b0)
      host_u.read_reg(fcr_pkg::OFS_MISC_CONFIG_THREE, rd);
      `CHK(rd, 8'h02)
      // second reset in mid-run
      rst_b = 1'b0;
      cyc(2);
      `CHK({fan_dac_out, fan_pwm_out}, 9'h1FF)
      rst_b = 1'b1;
      host_u.read_reg(fcr_pkg::OFS_FAN_HI_DIVISOR, rd);
      `CHK(rd, 8'h55)
      end_of_test();
   end
endmodule // fcr_bank_test

bind fcr_bank fcr_bank_sva chk_u (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .dac_afc_en(dac_afc_en), .pwm_afc_en(pwm_afc_en), .afc_dac_level(afc_dac_level),
   .afc_pwm_code(afc_pwm_code), .fan_dac_out(fan_dac_out), .fan_pwm_out(fan_pwm_out),
   .fan_meas_tick(fan_meas_tick), .general_pin_enable(general_pin_enable), .pin_drv(pin_drv),
   .intrusion_event_pin(intrusion_event_pin), .chassis_intrusion_latch(chassis_intrusion_latch));
